//--- rtl/mbox_pkg.sv
/*
  shared constants for the dual-ported rom mailbox: window geometry,
  apb register map, field layouts, reset values and the mode encodings.
  assumes nothing of its surroundings.
*/
package mbox_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int          POD_AW       = 16;      // pod 0 byte address width
  localparam int          WIN_AW       = 11;      // 2048-byte window
  localparam int          BASE_W       = POD_AW - WIN_AW;  // 2k block index width
  localparam int          RA_AW        = 8;       // 256-byte read-address region
  localparam logic [BASE_W-1:0] BASE_RST = {BASE_W{1'b1}};  // top 2k of pod 0

  // ---------------------------------------------------------------
  // apb register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [11:0] A_BASE   = 12'h000;  // window block index
  localparam logic [11:0] A_RACFG  = 12'h004;  // read-address mode / burst
  localparam logic [11:0] A_RAEN   = 12'h008;  // enabled byte count of region
  localparam logic [11:0] A_RASTAT = 12'h00c;  // pending flag and offset
  localparam logic [11:0] A_MADDR  = 12'h010;  // processor memory address
  localparam logic [11:0] A_MDATA  = 12'h014;  // processor memory data
  localparam logic [11:0] A_MEMWIN = 12'h800;  // direct window, one byte per word

  // ---------------------------------------------------------------
  // field layouts and modes
  // ---------------------------------------------------------------
  localparam int          CFG_MODE_LSB  = 0;   // two-bit protocol mode
  localparam int          CFG_BURST_LSB = 2;   // two-bit burst log2
  localparam int          STAT_PEND_BIT = 8;   // pending flag in status
  localparam logic [8:0]  EN_RW         = 9'h008;  // read-write protocol: 8 bytes
  localparam logic [8:0]  EN_ALL        = 9'h100;  // read-only protocol: whole region

  typedef enum logic [1:0] {
    MODE_OFF  = 2'b00,   // no mailbox protocol
    MODE_RW   = 2'b01,   // read-write target
    MODE_RO   = 2'b10,   // read-only target
    MODE_USER = 2'b11    // enable count taken from register
  } ra_mode_t;

  // message record flag bits (processor firmware and target share them)
  localparam int          FLG_READY = 0;
  localparam int          FLG_START = 1;
  localparam int          FLG_END   = 2;
  localparam int          FLG_LAST  = 3;

endpackage : mbox_pkg

//--- rtl/mbox_dpram.sv
/*
  2048 x 8 true dual-ported memory; port a is the target, port b the
  processor. read data come out of a register.
  assumes synchronous writes and one clock.
*/
`timescale 1ns/100ps
module mbox_dpram (
  // clock
  input  wire logic        pclk,
  // target port
  input  wire logic        a_en,
  input  wire logic        a_we,
  input  wire logic [10:0] a_addr,
  input  wire logic [7:0]  a_wdata,
  output      logic [7:0]  a_rdata_ff,
  // processor port
  input  wire logic        b_en,
  input  wire logic        b_we,
  input  wire logic [10:0] b_addr,
  input  wire logic [7:0]  b_wdata,
  output      logic [7:0]  b_rdata_ff
);

  logic [7:0] mem_ff [0:2047];  // storage cells

  // both write ports in one process; on a same-address clash the core
  // keeps the processor from writing, so the two never meet on one cell
  always_ff @(posedge pclk) begin
    if (a_en && a_we) begin
      mem_ff[a_addr] <= a_wdata;
    end
    if (b_en && b_we) begin
      mem_ff[b_addr] <= b_wdata;
    end
  end

  // target read register
  always_ff @(posedge pclk) begin
    if (a_en) begin
      a_rdata_ff <= mem_ff[a_addr];
    end
  end

  // processor read register
  always_ff @(posedge pclk) begin
    if (b_en) begin
      b_rdata_ff <= mem_ff[b_addr];
    end
  end

endmodule : mbox_dpram

//--- rtl/mbox_core.sv
/*
  dual-ported rom mailbox for emulation pod 0: relocatable 2k window,
  same-address busy hold-off for the processor, read-address latch with
  interrupt, apb register slave for the processor.
  assumes target rom pins arrive asynchronously and are synchronised
  here; the target cycle is a strobe that stays high for its duration.
*/
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
module mbox_core (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output      logic [31:0] prdata,
  output      logic        pready,
  output      logic        pslverr,
  // target rom bus (asynchronous pins)
  input  wire logic        tgt_cyc,
  input  wire logic        tgt_we,
  input  wire logic [15:0] tgt_addr,
  input  wire logic [7:0]  tgt_wdata,
  output      logic [7:0]  tgt_rdata,
  output      logic        tgt_hit,
  // emulation ram of pod 0 (outside the window)
  output      logic        emu_sel,
  input  wire logic [7:0]  emu_rdata,
  // processor-side status
  output      logic        ra_irq,
  output      logic        addr_busy
);

  // ---------------------------------------------------------------
  // target pin synchronisers
  // ---------------------------------------------------------------
  logic        cyc_s1_ff, cyc_s2_ff, cyc_d_ff;  // strobe sync and previous
  logic        we_s1_ff,  we_s2_ff;             // direction sync
  logic [15:0] adr_s1_ff, adr_s2_ff;            // address sync
  logic [7:0]  wd_s1_ff,  wd_s2_ff;             // write data sync

  // two flops on every target pin before any logic looks at it
  // address, direction and data must be settled when the strobe is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc_s1_ff <= 1'b0;
      cyc_s2_ff <= 1'b0;
      cyc_d_ff  <= 1'b0;
      we_s1_ff  <= 1'b0;
      we_s2_ff  <= 1'b0;
      adr_s1_ff <= 16'h0000;
      adr_s2_ff <= 16'h0000;
      wd_s1_ff  <= 8'h00;
      wd_s2_ff  <= 8'h00;
    end else begin
      cyc_s1_ff <= tgt_cyc;
      cyc_s2_ff <= cyc_s1_ff;
      cyc_d_ff  <= cyc_s2_ff;
      we_s1_ff  <= tgt_we;
      we_s2_ff  <= we_s1_ff;
      adr_s1_ff <= tgt_addr;
      adr_s2_ff <= adr_s1_ff;
      wd_s1_ff  <= tgt_wdata;
      wd_s2_ff  <= wd_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [mbox_pkg::BASE_W-1:0] base_ff;      // window block index
  mbox_pkg::ra_mode_t          mode_ff;      // read-address protocol mode
  logic [1:0]                  burst_ff;     // log2 of burst length
  logic [8:0]                  raen_ff;      // user enable count
  logic [10:0]                 maddr_ff;     // processor memory pointer
  logic                        pend_ff;      // offset latched, not yet read
  logic [7:0]                  ofs_ff;       // latched offset
  logic [2:0]                  bcnt_ff;      // burst beats still to swallow, up to seven

  // window hit for any pod address
  function automatic logic in_win(input logic [15:0] a,
                                  input logic [mbox_pkg::BASE_W-1:0] b);
    in_win = (a[15:mbox_pkg::WIN_AW] == b);
  endfunction : in_win

  // enabled byte count of the read-address region
  function automatic logic [8:0] en_count(input mbox_pkg::ra_mode_t m,
                                          input logic [8:0] u);
    unique case (m)
      mbox_pkg::MODE_OFF:  en_count = 9'h000;
      mbox_pkg::MODE_RW:   en_count = mbox_pkg::EN_RW;
      mbox_pkg::MODE_RO:   en_count = mbox_pkg::EN_ALL;
      mbox_pkg::MODE_USER: en_count = u;
    endcase
  endfunction : en_count

  // ---------------------------------------------------------------
  // target side decode
  // ---------------------------------------------------------------
  logic        t_start;   // first cycle of a target access
  logic        t_win;     // access falls inside the window
  logic [10:0] t_off;     // window offset
  logic        t_ra;      // access hits an enabled read-address byte

  assign t_start = cyc_s2_ff && !cyc_d_ff;
  assign t_win   = in_win(adr_s2_ff, base_ff);
  assign t_off   = adr_s2_ff[mbox_pkg::WIN_AW-1:0];
  // region sits at the window's low end; writes count as well
  assign t_ra    = t_win && (t_off[10:8] == 3'b000)
                 && ({1'b0, t_off[7:0]} < en_count(mode_ff, raen_ff));

  // outside the window the ordinary emulation ram answers
  assign emu_sel = cyc_s2_ff && !t_win;
  assign tgt_hit = cyc_s2_ff && t_win;

  // ---------------------------------------------------------------
  // apb decode and processor memory port
  // ---------------------------------------------------------------
  logic        acc;        // apb access phase
  logic        mem_acc;    // access reaches dual-port memory
  logic [10:0] m_addr;     // processor memory address
  logic        p_ph_ff;    // memory read issued last cycle, data valid now
  logic        collide;    // same address as a live target cycle

  assign acc     = psel && penable;
  assign mem_acc = acc && (paddr[11] || (paddr == mbox_pkg::A_MDATA));
  assign m_addr  = paddr[11] ? {2'b00, paddr[10:2]} : maddr_ff;
  // target keeps the cell for its whole cycle, start cycle included
  assign collide   = cyc_s2_ff && t_win && (t_off == m_addr);
  // busy drops in the cycle where a read already under way completes
  assign addr_busy = mem_acc && collide && !p_ph_ff;

  logic [7:0] t_rd, p_rd;  // memory read data

  // firmware lays records out byte by byte; the port only stores them
  // port a never waits on port b
  mbox_dpram u_ram (
    .pclk       (pclk),
    .a_en       (cyc_s2_ff && t_win),
    .a_we       (t_start && we_s2_ff),
    .a_addr     (t_off),
    .a_wdata    (wd_s2_ff),
    .a_rdata_ff (t_rd),
    .b_en       (mem_acc && !collide && !p_ph_ff),
    .b_we       (pwrite),
    .b_addr     (m_addr),
    .b_wdata    (pwdata[7:0]),
    .b_rdata_ff (p_rd)
  );

  // window reads come from the read register, the rest from pod ram
  assign tgt_rdata = t_win ? t_rd : emu_rdata;

  // read data valid one cycle after the memory port fires
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      p_ph_ff <= 1'b0;
    end else if (mem_acc && !collide && !p_ph_ff && !pwrite) begin
      p_ph_ff <= 1'b1;
    end else begin
      p_ph_ff <= 1'b0;
    end
  end

  // writes finish at once; reads after the data register; busy waits
  always_comb begin
    if (!mem_acc) begin
      pready = 1'b1;
    end else if (pwrite) begin
      pready = !collide;
    end else begin
      pready = p_ph_ff;
    end
  end

  // unmapped offsets answer at once with pslverr and change nothing
  logic known;  // address maps to something
  assign known = paddr[11] || (paddr == mbox_pkg::A_BASE) || (paddr == mbox_pkg::A_RACFG)
              || (paddr == mbox_pkg::A_RAEN) || (paddr == mbox_pkg::A_RASTAT)
              || (paddr == mbox_pkg::A_MADDR) || (paddr == mbox_pkg::A_MDATA);
  assign pslverr = acc && pready && !known;

  // read mux
  always_comb begin
    prdata = 32'h0000_0000;
    if (mem_acc) begin
      prdata = {24'h000000, p_rd};
    end else if (paddr == mbox_pkg::A_BASE) begin
      prdata = {{(32-mbox_pkg::BASE_W){1'b0}}, base_ff};
    end else if (paddr == mbox_pkg::A_RACFG) begin
      prdata = {28'h0000000, burst_ff, mode_ff};
    end else if (paddr == mbox_pkg::A_RAEN) begin
      prdata = {23'h000000, raen_ff};
    end else if (paddr == mbox_pkg::A_RASTAT) begin
      prdata = {23'h000000, pend_ff, ofs_ff};
    end else if (paddr == mbox_pkg::A_MADDR) begin
      prdata = {21'h000000, maddr_ff};
    end
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  // a write lands only at the edge where pready is sampled high
  logic wr;  // completing register write
  assign wr = acc && pwrite && pready;

  // configuration; reset returns the window to the top block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_ff  <= mbox_pkg::BASE_RST;
      mode_ff  <= mbox_pkg::MODE_OFF;
      burst_ff <= 2'b00;
      raen_ff  <= 9'h000;
      maddr_ff <= 11'h000;
    end else if (wr) begin
      if (paddr == mbox_pkg::A_BASE) begin
        base_ff <= pwdata[mbox_pkg::BASE_W-1:0];
      end
      if (paddr == mbox_pkg::A_RACFG) begin
        mode_ff  <= mbox_pkg::ra_mode_t'(pwdata[mbox_pkg::CFG_MODE_LSB +: 2]);
        burst_ff <= pwdata[mbox_pkg::CFG_BURST_LSB +: 2];
      end
      if (paddr == mbox_pkg::A_RAEN) begin
        raen_ff <= pwdata[8:0];
      end
      if (paddr == mbox_pkg::A_MADDR) begin
        maddr_ff <= pwdata[10:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read-address latch
  // ---------------------------------------------------------------
  logic svc;   // processor reads the latched offset
  logic hit;   // countable read-address access
  // reading the status clears pending; a hit in that same cycle is dropped
  assign svc = acc && !pwrite && (paddr == mbox_pkg::A_RASTAT) && pend_ff;
  assign hit = t_start && t_ra && (bcnt_ff == 3'b000);

  // first access wins; a new one only after the offset is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_ff <= 1'b0;
      ofs_ff  <= 8'h00;
    end else if (hit && !pend_ff) begin
      pend_ff <= 1'b1;
      ofs_ff  <= t_off[7:0];
    end else if (svc) begin
      pend_ff <= 1'b0;
    end
  end

  // later beats of one burst are swallowed as one event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcnt_ff <= 3'b000;
    end else if (hit) begin
      bcnt_ff <= 3'((1 << burst_ff) - 1);
    end else if (t_start && t_ra) begin
      bcnt_ff <= bcnt_ff - 3'b001;
    end
  end

  // interrupt level follows the pending flag until it is serviced
  assign ra_irq = pend_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_reset_base: assert property (@(posedge pclk)
    $rose(presetn) |-> base_ff == mbox_pkg::BASE_RST)
    else $error("window base not at top after reset");
  a_busy_stall: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_acc && pwrite && collide) |-> !pready)
    else $error("processor write done during target clash");
  a_irq_latch: assert property (@(posedge pclk) disable iff (!presetn)
    (hit && !pend_ff) |=> (ra_irq && ofs_ff == $past(t_off[7:0])))
    else $error("read-address hit not latched");
  a_first_only: assert property (@(posedge pclk) disable iff (!presetn)
    (pend_ff && !svc) |=> $stable(ofs_ff) && pend_ff)
    else $error("pending offset overwritten");
  a_off_silent: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ff == mbox_pkg::MODE_OFF) |-> !t_ra)
    else $error("read-address active with no protocol");
  a_rw_eight: assert property (@(posedge pclk) disable iff (!presetn)
    (mode_ff == mbox_pkg::MODE_RW && t_ra) |-> t_off < 11'd8)
    else $error("read-write region beyond eight bytes");
  a_emu_uncover: assert property (@(posedge pclk) disable iff (!presetn)
    (cyc_s2_ff && !in_win(adr_s2_ff, base_ff)) |-> emu_sel && !tgt_hit)
    else $error("emulation ram not exposed outside window");
  a_read_turn: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_acc && !pwrite && !collide && !p_ph_ff) |=> pready)
    else $error("clash-free read not done in two cycles");
  // clash handling, read-address service and burst swallowing
  a_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
    addr_busy |-> !pready)
    else $error("processor access done while held off");
  a_clash_noread: assert property (@(posedge pclk) disable iff (!presetn)
    (mem_acc && !pwrite && collide && !p_ph_ff) |=> !p_ph_ff)
    else $error("processor read issued over a live target cycle");
  a_svc_clear: assert property (@(posedge pclk) disable iff (!presetn)
    svc |=> !pend_ff)
    else $error("pending flag kept after status read");
  a_burst_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    (t_start && t_ra && (bcnt_ff != 3'b000) && !pend_ff) |=> !pend_ff)
    else $error("burst beat raised a new event");
  c_hit: cover property (@(posedge pclk) disable iff (!presetn) hit && !pend_ff);
  c_busy: cover property (@(posedge pclk) disable iff (!presetn) addr_busy);
  c_svc: cover property (@(posedge pclk) disable iff (!presetn) svc);
  c_burst: cover property (@(posedge pclk) disable iff (!presetn)
    t_start && t_ra && (bcnt_ff != 3'b000));
  c_wr_clash: cover property (@(posedge pclk) disable iff (!presetn)
    mem_acc && pwrite && collide);

endmodule : mbox_core

//--- bench/tgt_model.sv
/*
  target-side model: rom bus cycles into pod 0, held for a chosen span.
  assumes the bench owns the clock and calls the tasks one at a time.
*/
`timescale 1ns/100ps
module tgt_model (
  // clock
  input  wire logic        pclk,
  // rom bus towards the device
  output      logic        tgt_cyc,
  output      logic        tgt_we,
  output      logic [15:0] tgt_addr,
  output      logic [7:0]  tgt_wdata,
  input  wire logic [7:0]  tgt_rdata
);
  // ---------------------------------------------------------------
  // bus cycles
  // ---------------------------------------------------------------
  // idle bus at time zero
  initial begin
    tgt_cyc   = 1'b0;
    tgt_we    = 1'b0;
    tgt_addr  = 16'h0000;
    tgt_wdata = 8'h00;
  end

  // one rom cycle; the target never waits on the device
  task automatic access(input logic we, input logic [15:0] a, input logic [7:0] d,
                        input int hold, output logic [7:0] rd);
    @(posedge pclk);
    tgt_cyc   <= 1'b1;
    tgt_we    <= we;
    tgt_addr  <= a;
    tgt_wdata <= we ? d : ~tgt_wdata;
    repeat (hold) @(posedge pclk);
    rd = tgt_rdata;
    tgt_cyc   <= 1'b0;
    tgt_we    <= 1'b0;
    tgt_wdata <= ~tgt_wdata;  // no longer driven: show the inverse
    repeat (3) @(posedge pclk);  // idle gap above two clocks
  endtask : access

  // poll until two reads in a row agree
  task automatic read_stable(input logic [15:0] a, output logic [7:0] v);
    logic [7:0] prev;
    access(1'b0, a, 8'h00, 5, prev);
    access(1'b0, a, 8'h00, 5, v);
    while (v !== prev) begin
      prev = v;
      access(1'b0, a, 8'h00, 5, v);
    end
  endtask : read_stable
endmodule : tgt_model

//--- bench/test_mbox_core.sv
/*
  testbench of the mailbox core: apb master tasks, target model, checks.
  assumes the package constants and the core's apb and target timing.
*/
`timescale 1ns/100ps
module test_mbox_core;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam logic [15:0] WIN = 16'hf800;  // default window base
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        tgt_cyc;
  logic        tgt_we;
  logic [15:0] tgt_addr;
  logic [7:0]  tgt_wdata;
  logic [7:0]  tgt_rdata;
  logic [7:0]  emu_rdata;
  logic        ra_irq;
  logic        addr_busy;
  logic        tgt_hit;
  logic        emu_sel;
  logic [1:0]  seen = 2'b00;  // window hit and emulation select seen
  int          n_mismatch = 0;
  int          n_checks = 0;
  int          nb = 0;        // cycles with busy seen
  logic [31:0] r;
  logic        e;
  logic [7:0]  t;

  // emulation ram outside the window: a pattern of the address
  assign emu_rdata = tgt_addr[7:0] ^ 8'h5a;

  mbox_core i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tgt_cyc(tgt_cyc), .tgt_we(tgt_we), .tgt_addr(tgt_addr),
    .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata), .tgt_hit(tgt_hit), .emu_sel(emu_sel),
    .emu_rdata(emu_rdata), .ra_irq(ra_irq), .addr_busy(addr_busy));
  tgt_model tm (.pclk(pclk), .tgt_cyc(tgt_cyc), .tgt_we(tgt_we), .tgt_addr(tgt_addr),
    .tgt_wdata(tgt_wdata), .tgt_rdata(tgt_rdata));

  // ---------------------------------------------------------------
  // clock, monitor, tasks
  // ---------------------------------------------------------------
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  // count busy cycles, note which side answered the target
  always @(posedge pclk) begin
    if (addr_busy === 1'b1) nb <= nb + 1;
    if (tgt_hit === 1'b1) seen[1] <= 1'b1;
    if (emu_sel === 1'b1) seen[0] <= 1'b1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; waits for pready, only the watchdog ends a hang
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rd_chk
  function automatic logic [11:0] mw(input logic [9:0] n);
    return mbox_pkg::A_MEMWIN + {n, 2'b00};
  endfunction : mw

  // target access into the region under one config, then service it
  task automatic ra_case(input logic [31:0] cfg, input logic [7:0] off, input logic we,
                         input logic hit);
    wr(mbox_pkg::A_RACFG, cfg);
    tm.access(we, WIN + 16'(off), 8'h77, 5, t);
    chk(32'(ra_irq), 32'(hit));
    if (hit) rd_chk(mbox_pkg::A_RASTAT, 32'h100 | 32'(off));
    @(posedge pclk);  // the clear shows only after the status-read edge
    chk(32'(ra_irq), 32'h0);
  endtask : ra_case

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(mbox_pkg::A_BASE, 32'h1f);
    rd_chk(mbox_pkg::A_RACFG, 32'h0);
    apb(1'b0, 12'h020, 32'h0, r, e);
    chk(32'(e), 32'h1);
    chk(r, 32'h0);
    // both ports, the window's top edge and pointer access
    wr(mw(10'h110), 32'ha5);
    wr(mbox_pkg::A_MADDR, 32'h7ff);
    wr(mbox_pkg::A_MDATA, 32'hc3);
    tm.access(1'b0, WIN + 16'h0110, 8'h00, 5, t);
    chk(32'(t), 32'ha5);
    tm.access(1'b0, 16'hffff, 8'h00, 5, t);
    chk(32'(t), 32'hc3);
    tm.access(1'b1, WIN + 16'h0120, 8'h3c, 5, t);
    rd_chk(mw(10'h120), 32'h3c);
    // same address: processor stalled until the target is done
    nb = 0;
    fork
      tm.access(1'b0, WIN + 16'h0110, 8'h00, 20, t);
      begin
        repeat (6) @(posedge pclk);
        rd_chk(mw(10'h110), 32'ha5);
      end
    join
    chk(32'(t), 32'ha5);
    chk(32'(nb > 0), 32'h1);
    // different addresses at once: no stall, both correct
    nb = 0;
    fork
      tm.access(1'b0, WIN + 16'h0110, 8'h00, 20, t);
      begin
        repeat (6) @(posedge pclk);
        rd_chk(mw(10'h120), 32'h3c);
      end
    join
    chk(32'(t), 32'ha5);
    chk(32'(nb), 32'h0);
    // processor write to the cell the target reads: held off, then lands
    nb = 0;
    fork
      tm.access(1'b0, WIN + 16'h0120, 8'h00, 20, t);
      begin
        repeat (6) @(posedge pclk);
        wr(mw(10'h120), 32'h5c);
      end
    join
    chk(32'(t), 32'h3c);
    chk(32'(nb > 0), 32'h1);
    rd_chk(mw(10'h120), 32'h5c);
    // message record: data, big-endian size, then flags last
    wr(mw(10'h184), 32'h11);
    wr(mw(10'h182), 32'h01);
    wr(mw(10'h183), 32'h02);
    wr(mw(10'h180), 32'h0f);
    tm.read_stable(WIN + 16'h0180, t);
    chk(32'(t), 32'h0f);
    tm.access(1'b0, WIN + 16'h0182, 8'h00, 5, t);
    chk(32'(t), 32'h01);
    // relocation to block 2
    wr(mbox_pkg::A_BASE, 32'h02);
    rd_chk(mbox_pkg::A_BASE, 32'h02);
    seen = 2'b00;
    tm.access(1'b0, 16'h1110, 8'h00, 5, t);
    chk(32'(t), 32'ha5);
    chk(32'(seen), 32'h2);
    seen = 2'b00;
    tm.access(1'b0, WIN + 16'h0110, 8'h00, 5, t);
    chk(32'(t), 32'h4a);
    chk(32'(seen), 32'h1);
    // reset in mid-run brings the window home
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(mbox_pkg::A_BASE, 32'h1f);
    tm.access(1'b0, 16'h1110, 8'h00, 5, t);
    chk(32'(t), 32'h4a);
    // read-address region under every mode
    wr(mbox_pkg::A_RAEN, 32'h10);
    ra_case(32'h0, 8'h05, 1'b0, 1'b0);
    ra_case(32'h1, 8'h07, 1'b0, 1'b1);
    ra_case(32'h1, 8'h08, 1'b0, 1'b0);
    ra_case(32'h1, 8'h04, 1'b1, 1'b1);
    rd_chk(mw(10'h004), 32'h77);
    ra_case(32'h2, 8'hff, 1'b0, 1'b1);
    ra_case(32'h3, 8'h0f, 1'b0, 1'b1);
    ra_case(32'h3, 8'h10, 1'b0, 1'b0);
    // only the first access is latched until serviced
    wr(mbox_pkg::A_RACFG, 32'h1);
    tm.access(1'b0, WIN + 16'h0003, 8'h00, 5, t);
    tm.access(1'b0, WIN + 16'h0002, 8'h00, 5, t);
    rd_chk(mbox_pkg::A_RASTAT, 32'h103);
    ra_case(32'h1, 8'h02, 1'b0, 1'b1);
    // burst of four is one event
    ra_case(32'h9, 8'h00, 1'b0, 1'b1);
    for (int i = 1; i < 4; i++) begin
      tm.access(1'b0, WIN + 16'(i), 8'h00, 5, t);
    end
    chk(32'(ra_irq), 32'h0);
    ra_case(32'h9, 8'h04, 1'b0, 1'b1);
    conclude();
  end

  // watchdog against a hang
  initial begin
    repeat (50000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
endmodule : test_mbox_core
